//--- verilog/eeprom_pkg.sv
// constants, encodings and helpers shared by both ends of the two-wire memory link
// assumes a 40 MHz system clock on each end; the serial clock is made by the master end
package eeprom_pkg;

   localparam int SYS_CLK_HZ          = 40_000_000;
   localparam int WRITE_CYCLE_TIME_MS = 5;
   // longest time, so the count rounds down
   localparam int WRITE_CYCLE_CNT     = WRITE_CYCLE_TIME_MS * (SYS_CLK_HZ / 1000);
   localparam int BUSY_W              = 18;

   localparam int SCL_FREQ_KHZ        = 400;
   localparam int SCL_QTR_CNT         = SYS_CLK_HZ / (SCL_FREQ_KHZ * 1000 * 4);
   localparam int QTR_W               = 5;

   localparam int MEM_DEPTH           = 256;
   localparam int PAGE_BYTES          = 8;
   localparam int ADDR_W              = 8;
   localparam int PAGE_W              = 3;

   localparam logic [3:0] DEV_TYPE_CODE = 4'hA;
   localparam logic [3:0] ACK_SLOT      = 4'h8;
   localparam logic [3:0] ACK_DONE      = 4'h9;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;
   localparam logic [3:0] BYTE_LAST_SLOT    = 4'h8;
   localparam logic [3:0] RECOVER_RESTART   = 4'hA;
   localparam logic [3:0] RECOVER_LAST_SLOT = 4'hB;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_DEV   = 3'h1,
      ST_WADDR = 3'h3,
      ST_WDATA = 3'h2,
      ST_RDATA = 3'h6,
      ST_SKIP  = 3'h7
   } dev_state_t;

   typedef enum logic [2:0] {
      OP_START   = 3'h0,
      OP_STOP    = 3'h1,
      OP_WRITE   = 3'h2,
      OP_READ    = 3'h3,
      OP_RECOVER = 3'h4
   } host_op_t;

   typedef enum logic [1:0] {
      SLOT_START = 2'h0,
      SLOT_BIT   = 2'h1,
      SLOT_STOP  = 2'h2
   } slot_kind_t;

   typedef enum logic {
      H_IDLE = 1'b0,
      H_RUN  = 1'b1
   } host_state_t;

   // next write address: low bits wrap inside the page, page row stays
   function automatic logic [ADDR_W-1:0] page_inc(input logic [ADDR_W-1:0] a);
      page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 3'h1};
   endfunction

endpackage

//--- verilog/twi_if.sv
// two-wire link between the master end and the memory end
// the open-drain data wire is resolved here from both ends' enables
interface twi_if;
   logic scl;
   logic sda;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;

   // wired-and with pull-up: a driver pulls low only while its enable is low
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport dev  (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host (output scl, input sda, output host_sda_o, output host_sda_oe_n);
endinterface

//--- verilog/sync2.sv
// two-flop synchroniser for levels entering the system clock domain
// idles high, matching a pulled-up bus after reset
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_r <= '1;
         q      <= '1;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule // sync2

//--- verilog/eeprom_dev.sv
// memory end of the two-wire link: 256 x 8 array, page writes, reads, timed write cycle
// assumes the master keeps bus timing; scl is the link clock, sys_clk runs the protocol

////////////////////////////////////////////////////////////////////////////////
module eeprom_dev
   import eeprom_pkg::*;
#(
   parameter int WR_CYCLES = WRITE_CYCLE_CNT
) (
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic select_pin_2,
   input  wire logic select_pin_1,
   input  wire logic select_pin_0,
   input  wire logic write_protect,
   output logic      standby,
   output logic      write_busy,
   twi_if.dev        tw
);

   ////////////////////////////////////////////////////////////////////////////////
   // declarations

   logic [5:0]        pin_s;
   logic              scl_s;
   logic              sda_s;
   logic [2:0]        sel_s;
   logic              wp_s;
   logic              scl_d_r;
   logic              sda_d_r;
   logic              rx_bit_r;
   logic              scl_rise;
   logic              scl_fall;
   logic              start_ev;
   logic              stop_ev;
   logic              dev_hit;
   logic              commit;

   dev_state_t        state_r;
   logic [3:0]        bcnt_r;
   logic              rd_go_r;
   logic              drv_low_r;
   logic [7:0]        sh_r;
   logic [7:0]        tx_r;
   logic [ADDR_W-1:0] addr_r;
   logic [7:0]        mem     [MEM_DEPTH];
   logic [7:0]        pbuf    [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] pvalid_r;
   logic [BUSY_W-1:0] busy_cnt_r;
   logic              busy_r;

   ////////////////////////////////////////////////////////////////////////////////
   // link clock domain: only the bit capture lives here

   // held until the next rising edge, so the system side reads it safely
   // once it has seen the synchronised rise
   always_ff @(posedge tw.scl) begin
      rx_bit_r <= tw.sda;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and bus events

   sync2 #(
      .W (6)
   ) u_pin_sync (
      .clk  (sys_clk),
      .nrst (nrst),
      .d    ({tw.scl, tw.sda, select_pin_2, select_pin_1, select_pin_0, write_protect}),
      .q    (pin_s)
   );

   assign scl_s = pin_s[5];
   assign sda_s = pin_s[4];
   assign sel_s = pin_s[3:1];
   assign wp_s  = pin_s[0];

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_d_r;
   assign scl_fall = ~scl_s & scl_d_r;
   // a data edge with the clock steady high is never a bit
   assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_ev  = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // a busy array answers no address, which is what polling looks for
   assign dev_hit = (sh_r[7:4] == DEV_TYPE_CODE)
                    && (sh_r[3:1] == sel_s)
                    && !busy_r;

   assign commit = stop_ev && (state_r == ST_WDATA) && (|pvalid_r)
                   && !wp_s && !busy_r;

   ////////////////////////////////////////////////////////////////////////////////
   // protocol sequencer: state, bit count, data line drive

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r   <= ST_IDLE;
         bcnt_r    <= 4'h0;
         rd_go_r   <= 1'b0;
         drv_low_r <= 1'b0;
      end else if (start_ev) begin
         state_r   <= ST_DEV;
         bcnt_r    <= 4'h0;
         drv_low_r <= 1'b0;
      end else if (stop_ev) begin
         state_r   <= ST_IDLE;
         drv_low_r <= 1'b0;
      end else if (scl_rise && state_r != ST_IDLE) begin
         if (bcnt_r != ACK_DONE) begin
            bcnt_r <= bcnt_r + 4'h1;
         end
         // master answer on the ninth clock; our own ack reads as go too
         if (state_r == ST_RDATA && bcnt_r == ACK_SLOT) begin
            rd_go_r <= ~rx_bit_r;
         end
      end else if (scl_fall) begin
         case (state_r)
            ST_DEV: begin
               if (bcnt_r == ACK_SLOT) begin
                  if (dev_hit) begin
                     drv_low_r <= 1'b1;
                     state_r   <= sh_r[0] ? ST_RDATA : ST_WADDR;
                  end else begin
                     state_r   <= ST_IDLE;
                  end
               end
            end
            ST_WADDR, ST_WDATA: begin
               if (bcnt_r == ACK_SLOT) begin
                  drv_low_r <= 1'b1;
                  state_r   <= ST_WDATA;
               end else if (bcnt_r == ACK_DONE) begin
                  drv_low_r <= 1'b0;
                  bcnt_r    <= 4'h0;
               end
            end
            ST_RDATA: begin
               if (bcnt_r == ACK_DONE) begin
                  bcnt_r <= 4'h0;
                  if (rd_go_r) begin
                     drv_low_r <= ~mem[addr_r][7];
                  end else begin
                     drv_low_r <= 1'b0;
                     state_r   <= ST_SKIP;
                  end
               end else if (bcnt_r == ACK_SLOT) begin
                  drv_low_r <= 1'b0;
               end else if (bcnt_r != 4'h0) begin
                  drv_low_r <= ~tx_r[6];
               end
            end
            default: begin
               drv_low_r <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // shift registers, address counter, page buffer

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         sh_r     <= 8'h00;
         tx_r     <= 8'h00;
         addr_r   <= 8'h00;
         pvalid_r <= 8'h00;
      end else begin
         // a restart or stop drops any bytes not yet committed
         if (start_ev || stop_ev) begin
            pvalid_r <= 8'h00;
         end
         if (scl_rise && bcnt_r <= LAST_DATA_BIT) begin
            sh_r <= {sh_r[6:0], rx_bit_r};
         end
         if (scl_fall) begin
            if (state_r == ST_WADDR && bcnt_r == ACK_SLOT) begin
               addr_r   <= sh_r;
               pvalid_r <= 8'h00;
            end
            if (state_r == ST_WDATA && bcnt_r == ACK_SLOT) begin
               pbuf[addr_r[PAGE_W-1:0]]     <= sh_r;
               pvalid_r[addr_r[PAGE_W-1:0]] <= 1'b1;
               addr_r                       <= page_inc(addr_r);
            end
            if (state_r == ST_RDATA && bcnt_r == ACK_DONE && rd_go_r) begin
               tx_r   <= mem[addr_r];
               addr_r <= addr_r + 8'h01;
            end
            if (state_r == ST_RDATA && bcnt_r != 4'h0 && bcnt_r <= LAST_DATA_BIT) begin
               tx_r <= {tx_r[6:0], 1'b0};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // array: 32 pages of 8 bytes, content not cleared by reset

   always_ff @(posedge sys_clk) begin
      if (commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (pvalid_r[i]) begin
               mem[{addr_r[ADDR_W-1:PAGE_W], 3'(i)}] <= pbuf[i];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // self-timed write cycle; the array is updated at once, the timer only
   // models how long the part stays deaf

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         busy_r     <= 1'b0;
         busy_cnt_r <= '0;
      end else if (commit) begin
         busy_r     <= 1'b1;
         busy_cnt_r <= '0;
      end else if (busy_r) begin
         if (busy_cnt_r == BUSY_W'(WR_CYCLES - 1)) begin
            busy_r <= 1'b0;
         end else begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs

   assign tw.dev_sda_o    = 1'b0;
   assign tw.dev_sda_oe_n = ~drv_low_r;
   assign standby         = (state_r == ST_IDLE) && !busy_r;
   assign write_busy      = busy_r;

endmodule // eeprom_dev

//--- verilog/twi_master.sv
// master end of the two-wire link: runs one bus primitive per command
// makes scl from sys_clk by a divider; higher-level sequences are the user's
module twi_master
   import eeprom_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic       cmd_valid,
   output logic            cmd_ready,
   input  wire host_op_t   cmd_op,
   input  wire logic [7:0] cmd_data,
   input  wire logic       cmd_ack,
   output logic            rsp_valid,
   output logic      [7:0] rsp_data,
   output logic            rsp_ack,
   twi_if.host             tw
);

   host_state_t      state_r;
   host_op_t         op_r;
   logic [QTR_W-1:0] div_r;
   logic [1:0]       qtr_r;
   logic [3:0]       slot_r;
   logic [8:0]       tx_r;
   logic [7:0]       rx_r;
   logic             ack_r;
   logic             scl_r;
   logic             sda_rel_r;
   logic             sda_s;
   logic             tick;
   slot_kind_t       kind;

   sync2 #(
      .W (1)
   ) u_sda_sync (
      .clk  (sys_clk),
      .nrst (nrst),
      .d    (tw.sda),
      .q    (sda_s)
   );

   function automatic slot_kind_t slot_of(input host_op_t op, input logic [3:0] s);
      case (op)
         OP_START:   slot_of = SLOT_START;
         OP_STOP:    slot_of = SLOT_STOP;
         // start, nine clocks released, start, stop
         OP_RECOVER: slot_of = (s == 4'h0 || s == RECOVER_RESTART) ? SLOT_START :
                               (s == RECOVER_LAST_SLOT) ? SLOT_STOP : SLOT_BIT;
         default:    slot_of = SLOT_BIT;
      endcase
   endfunction

   function automatic logic [3:0] last_of(input host_op_t op);
      case (op)
         OP_WRITE, OP_READ: last_of = BYTE_LAST_SLOT;
         OP_RECOVER:        last_of = RECOVER_LAST_SLOT;
         default:           last_of = 4'h0;
      endcase
   endfunction

   assign tick = (div_r == QTR_W'(SCL_QTR_CNT - 1));
   assign kind = slot_of(op_r, slot_r);

   ////////////////////////////////////////////////////////////////////////////////
   // primitive sequencer: four quarter periods per slot

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_r   <= H_IDLE;
         op_r      <= OP_START;
         div_r     <= '0;
         qtr_r     <= 2'h0;
         slot_r    <= 4'h0;
         tx_r      <= 9'h1FF;
         rx_r      <= 8'h00;
         ack_r     <= 1'b0;
         scl_r     <= 1'b1;
         sda_rel_r <= 1'b1;
         rsp_valid <= 1'b0;
         rsp_data  <= 8'h00;
         rsp_ack   <= 1'b0;
      end else begin
         rsp_valid <= 1'b0;
         if (state_r == H_IDLE) begin
            if (cmd_valid) begin
               state_r <= H_RUN;
               op_r    <= cmd_op;
               div_r   <= '0;
               qtr_r   <= 2'h0;
               slot_r  <= 4'h0;
               tx_r    <= (cmd_op == OP_WRITE) ? {cmd_data, 1'b1} :
                          (cmd_op == OP_READ)  ? {8'hFF, ~cmd_ack} : 9'h1FF;
            end
         end else begin
            div_r <= tick ? '0 : div_r + 1'b1;
            if (tick) begin
               qtr_r <= qtr_r + 2'h1;
               case (qtr_r)
                  2'h0: begin
                     // bit data moves only while scl is low; start and stop move it in quarter 2 with scl high
                     sda_rel_r <= (kind == SLOT_START) ? 1'b1 :
                                  (kind == SLOT_STOP)  ? 1'b0 : tx_r[8];
                  end
                  2'h1: begin
                     scl_r <= 1'b1;
                  end
                  2'h2: begin
                     if (kind == SLOT_START) begin
                        sda_rel_r <= 1'b0;
                     end else if (kind == SLOT_STOP) begin
                        sda_rel_r <= 1'b1;
                     end else if (slot_r == BYTE_LAST_SLOT) begin
                        ack_r <= ~sda_s;
                     end else begin
                        rx_r <= {rx_r[6:0], sda_s};
                     end
                  end
                  default: begin
                     if (kind != SLOT_STOP) begin
                        scl_r <= 1'b0;
                     end
                     // ones fill in behind the word, so the line stays released
                     // through the ninth recovery clock
                     tx_r <= {tx_r[7:0], 1'b1};
                     if (slot_r == last_of(op_r)) begin
                        state_r   <= H_IDLE;
                        rsp_valid <= 1'b1;
                        rsp_data  <= rx_r;
                        rsp_ack   <= ack_r;
                     end else begin
                        slot_r <= slot_r + 4'h1;
                     end
                  end
               endcase
            end
         end
      end
   end

   assign cmd_ready        = (state_r == H_IDLE);
   assign tw.scl           = scl_r;
   assign tw.host_sda_o    = 1'b0;
   assign tw.host_sda_oe_n = sda_rel_r;

endmodule // twi_master

//--- verif/eeprom_assertions.sv
// concurrent checks on the two-wire link and the memory end's status outputs
// assumes every signal is sampled on sys_clk, which runs far faster than scl
module eeprom_assertions #(
   parameter int WR_CYCLES = 1500
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic scl,
   input wire logic sda,
   input wire logic host_sda_oe_n,
   input wire logic dev_sda_oe_n,
   input wire logic standby,
   input wire logic write_busy
);
   int busy_cnt_r;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);

   // length of the deaf period, checked when it ends
   always_ff @(posedge sys_clk) begin
      if (!nrst || !write_busy) begin
         busy_cnt_r <= 0;
      end else begin
         busy_cnt_r <= busy_cnt_r + 1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   dev_stable_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
      else $error("memory end moved the data line while clock high");
   drive_low_a: assert property ($fell(dev_sda_oe_n) |-> !scl)
      else $error("memory end started driving while clock high");
   launch_delay_a: assert property ($fell(dev_sda_oe_n) |-> !$past(scl, 1) && $past(scl, 6))
      else $error("memory end drive not launched shortly after clock fall");
   idle_release_a: assert property (standby |-> dev_sda_oe_n)
      else $error("memory end drives the data line in standby");
   busy_deaf_a: assert property (write_busy |-> dev_sda_oe_n)
      else $error("memory end answered during its write cycle");
   busy_standby_a: assert property (write_busy |-> !standby)
      else $error("standby shown during write cycle");
   busy_start_a: assert property ($rose(write_busy) |-> scl && sda && $past(scl))
      else $error("write cycle began without a stop");
   busy_len_a: assert property ($fell(write_busy) |-> busy_cnt_r == WR_CYCLES)
      else $error("write cycle length wrong");
   stop_standby_a: assert property ($rose(sda) && scl && $past(scl) |-> ##[1:8] (standby || write_busy))
      else $error("no standby or write cycle after stop");

   cover property ($rose(write_busy));
   cover property ($fell(dev_sda_oe_n));
   cover property ($fell(host_sda_oe_n) && scl && $past(scl));
endmodule // eeprom_assertions

//--- verif/two_wire_eeprom_slave_tb_top.sv
// self-checking bench: master end and memory end joined over one two-wire link
// assumes the package constants; write cycle shortened so polling still meets a busy memory
module two_wire_eeprom_slave_tb_top
   import eeprom_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int WR_TB = 1500;
   logic       sys_clk = 1'b0;
   logic       nrst = 1'b0;
   logic       sel2, sel1, sel0, write_protect, cmd_valid, cmd_ack, cmd_ready;
   logic       rsp_valid, rsp_ack, standby, write_busy;
   host_op_t   cmd_op;
   logic [7:0] cmd_data, rsp_data, ctr;
   logic [2:0] sel;
   logic [7:0] mdl [256];
   logic [9:0] notes [$];
   logic [9:0] cur;
   int         err_count = 0;
   int         check_count = 0;
   int         cyc = 0;

   always #12.5 sys_clk = ~sys_clk;

   twi_if tw_bus ();
   eeprom_dev #(.WR_CYCLES(WR_TB)) i_eeprom_dev (.sys_clk(sys_clk), .nrst(nrst), .select_pin_2(sel2),
      .select_pin_1(sel1), .select_pin_0(sel0), .write_protect(write_protect), .standby(standby),
      .write_busy(write_busy), .tw(tw_bus.dev));
   twi_master i_twi_master (.sys_clk(sys_clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_ack(rsp_ack), .tw(tw_bus.host));
   eeprom_assertions #(.WR_CYCLES(WR_TB)) i_eeprom_assertions (.sys_clk(sys_clk), .nrst(nrst),
      .scl(tw_bus.scl), .sda(tw_bus.sda), .host_sda_oe_n(tw_bus.host_sda_oe_n),
      .dev_sda_oe_n(tw_bus.dev_sda_oe_n), .standby(standby), .write_busy(write_busy));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // kind 0 nothing, 1 ack bit, 2 read byte; note is queued before the command is offered
   task automatic cmd(input host_op_t op, input logic [7:0] d, input logic ak, input logic [1:0] kind,
                      input logic [7:0] ev);
      int n;
      notes.push_back({kind, ev});
      @(negedge sys_clk);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_data = d;
      cmd_ack = ak;
      n = 0;
      // ready is looked at between edges, so the accepting edge is the next one
      while (cmd_ready !== 1'b1 && n < 2000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 2000) err_count++;
      @(negedge sys_clk);
      cmd_valid = 1'b0;
   endtask

   task automatic start();
      cmd(OP_START, 8'h00, 1'b0, 2'h0, 8'h00);
   endtask

   task automatic stop();
      cmd(OP_STOP, 8'h00, 1'b0, 2'h0, 8'h00);
   endtask

   task automatic wb(input logic [7:0] b, input logic ak);
      cmd(OP_WRITE, b, 1'b0, 2'h1, {7'h00, ak});
   endtask

   function automatic logic [7:0] dw(input logic [2:0] s, input logic rd);
      return {DEV_TYPE_CODE, s, rd};
   endfunction

   task automatic drain();
      int n;
      n = 0;
      while (notes.size() != 0 && n < 3000) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 3000) err_count++;
      @(negedge sys_clk);
   endtask

   task automatic wait_free();
      int n;
      n = 0;
      while (write_busy === 1'b1 && n < 3000) begin
         @(negedge sys_clk);
         n++;
      end
      if (n >= 3000) err_count++;
   endtask

   task automatic wr_seq(input logic [7:0] a, input int n);
      logic [7:0] d;
      wait_free();
      start();
      wb(dw(sel, 1'b0), 1'b1);
      wb(a, 1'b1);
      for (int i = 0; i < n; i++) begin
         d = 8'($urandom);
         if (write_protect !== 1'b1) mdl[{a[7:3], a[2:0] + 3'(i)}] = d;
         wb(d, 1'b1);
      end
      stop();
      drain();
      chk("write_busy", {7'h00, write_busy}, {7'h00, ~write_protect});
   endtask

   task automatic rd_seq(input logic rnd, input logic [7:0] a, input int n);
      wait_free();
      if (rnd) begin
         start();
         wb(dw(sel, 1'b0), 1'b1);
         wb(a, 1'b1);
         ctr = a;
      end
      start();
      wb(dw(sel, 1'b1), 1'b1);
      for (int i = 0; i < n; i++) begin
         cmd(OP_READ, 8'h00, i != n - 1, 2'h2, mdl[ctr]);
         ctr = ctr + 8'h01;
      end
      stop();
      drain();
      chk("standby", {7'h00, standby}, 8'h01);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // the answer pulse stands one full cycle, so the falling edge sees it once, settled
   always @(negedge sys_clk) begin
      if (rsp_valid === 1'b1) begin
         cur = notes.pop_front();
         if (cur[9:8] == 2'h1) chk("ack", {7'h00, rsp_ack}, cur[7:0]);
         if (cur[9:8] == 2'h2) chk("read data", rsp_data, cur[7:0]);
      end
   end

   // ceiling well above the planned traffic of about 70k cycles
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 100000) begin
         err_count++;
         test_done();
      end
   end

   initial begin
      cmd_valid = 1'b0;
      cmd_op = OP_START;
      cmd_data = 8'h00;
      cmd_ack = 1'b0;
      write_protect = 1'b0;
      void'($urandom(32'hA9C520A4));
      sel = 3'($urandom);
      {sel2, sel1, sel0} = sel;
      repeat (20) @(negedge sys_clk);
      nrst = 1'b1;
      @(negedge sys_clk);
      chk("standby", {7'h00, standby}, 8'h01);
      wr_seq(8'h42, 1);
      // poll while the write cycle runs: no answer until it ends
      start();
      wb(dw(sel, 1'b0), 1'b0);
      stop();
      drain();
      wait_free();
      start();
      wb(dw(sel, 1'b0), 1'b1);
      stop();
      drain();
      chk("write_busy", {7'h00, write_busy}, 8'h00);
      wr_seq(8'h6D, 10);
      wr_seq(8'hFE, 2);
      wr_seq(8'h00, 2);
      rd_seq(1'b1, 8'h68, 8);
      rd_seq(1'b1, 8'hFE, 3);
      rd_seq(1'b0, 8'h00, 1);
      for (int k = 0; k < 3; k++) begin
         start();
         wb(dw(sel ^ (3'h1 << k), 1'b1), 1'b0);
      end
      start();
      wb({4'h5, sel, 1'b0}, 1'b0);
      stop();
      write_protect = 1'b1;
      wr_seq(8'h42, 1);
      write_protect = 1'b0;
      rd_seq(1'b1, 8'h42, 1);
      // aim the counter at written data, then cut a read short
      start();
      wb(dw(sel, 1'b0), 1'b1);
      wb(8'h6C, 1'b1);
      start();
      wb(dw(sel, 1'b1), 1'b1);
      cmd(OP_RECOVER, 8'h00, 1'b0, 2'h0, 8'h00);
      drain();
      rd_seq(1'b1, 8'h6A, 2);
      test_done();
   end
endmodule // two_wire_eeprom_slave_tb_top
